// ===== dca_arbiter.sv
/*
  Data channel arbiter: synchronises device requests at each memory
  cycle, grants nearest first, runs in/out/increment/add transfers
  and orders channel service ahead of interrupt entry.
  Assumes a memory whose read data follows the address in the same cycle and a CPU sequencer that
  flags instruction end and pause points.
*/
// What this block does
// RQ1: Sample and synchronise all pending channel requests at each memory cycle start.
// RQ2: Standard variant grants after instruction ends, serving every synchronised request.
// RQ3: Simultaneous requests go first to the interface nearest the processor.
// RQ4: Pausing variant serves all requests mid-instruction, high-speed first, then resumes.
// RQ5: After an instruction, serve channel first, then interrupt, else fetch.
// RQ6: Support word in, word out, increment by one and optional add.
// RQ7: Increment and add write the sum and return it to the interface.
// RQ8: Sum above largest 16-bit unsigned word raises overflow to the interface.
// RQ9: No program-visible controls; interfaces raise their own requests.
// RQ10: Many interfaces stay active, their word transfers interleaved.
// RQ11: High-speed interfaces sit nearest; nearer than last one run high speed.
// RQ12: Per transfer, speed chosen from the chained priority signal.
// RQ13: High-speed interfaces meet shortened strobes and reduced window.
// RQ14: Interrupt entry only after the whole instruction, indirection included.
// RQ15: Pending source query returns highest unmasked requester code, else zero.
// RQ16: Interfaces hold address and operation until their transfer completes.
`timescale 1ns/1ps
`default_nettype none

module dca_arbiter
import dca_pkg::*;
#(
  parameter int NDEV = DCA_NDEV,
  parameter int DEPTH = DCA_FIFO_DEPTH,
  parameter bit HAS_ADD = 1'b1,
  parameter bit PAUSING = 1'b0
)
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Device side
  input wire logic [NDEV-1:0] dev_req_in,
  input wire logic [NDEV-1:0] dev_hs_chain_in,
  input wire dca_req_s [NDEV-1:0] dev_cmd_in,
  output logic [NDEV-1:0] dev_done_out,
  output logic [NDEV-1:0] dev_ovf_out,
  output logic [DCA_WORD_W-1:0] dev_data_out,
  output logic dev_rsp_valid_out,
  input wire logic dev_rsp_ready_in,
  // Interrupt requests and mask for the source query
  input wire logic [NDEV-1:0] dev_irq_in,
  input wire logic [NDEV-1:0] irq_mask_in,
  input wire logic [DCA_CODE_W-1:0] dev_code_in [NDEV],
  input wire logic pending_source_query_in,
  output logic [DCA_CODE_W-1:0] pending_source_out,
  // CPU sequencer side
  input wire logic mem_cycle_start_in,
  input wire logic instr_end_in,
  input wire logic pause_point_in,
  input wire logic irq_pending_in,
  output logic chan_busy_out,
  output logic start_irq_out,
  output logic fetch_next_out,
  output logic resume_out,
  // Memory side
  output logic mem_en_out,
  output logic mem_we_out,
  output logic [DCA_ADDR_W-1:0] mem_addr_out,
  output logic [DCA_WORD_W-1:0] mem_wdata_out,
  input wire logic [DCA_WORD_W-1:0] mem_rdata_in
);
  localparam int IW = $clog2(NDEV);

  // ----------------------------------------------------------------
  // Request synchronisers
  // ----------------------------------------------------------------
  logic [NDEV-1:0] req_s1;
  logic [NDEV-1:0] req_s2;
  logic [NDEV-1:0] req_s3;
  logic [NDEV-1:0] req_clean;
  logic [NDEV-1:0] hs_s1;
  logic [NDEV-1:0] hs_s2;
  logic [NDEV-1:0] hs_s3;
  logic [NDEV-1:0] hs_clean;
  logic [NDEV-1:0] sync_req;
  logic [NDEV-1:0] served;

  // RQ9 device-raised requests
  // RQ11 tier from chain bits
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      req_s1 <= '0;
      req_s2 <= '0;
      req_s3 <= '0;
      hs_s1 <= '0;
      hs_s2 <= '0;
      hs_s3 <= '0;
    end
    else
    begin
      req_s1 <= dev_req_in;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      hs_s1 <= dev_hs_chain_in;
      hs_s2 <= hs_s1;
      hs_s3 <= hs_s2;
    end
  end

  // A change counts once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < NDEV; g++)
    begin : g_clean
      always_ff @(posedge core_clk_in)
      begin
        if (!resetn_in)
        begin
          req_clean[g] <= 1'b0;
          hs_clean[g] <= 1'b0;
        end
        else
        begin
          if (req_s2[g] == req_s3[g])
          begin
            req_clean[g] <= req_s3[g];
          end
          if (hs_s2[g] == hs_s3[g])
          begin
            hs_clean[g] <= hs_s3[g];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Arbitration state
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b010,
    ST_HOLD = 3'b011,
    ST_EXIT = 3'b100
  } dca_state_e;

  dca_state_e state;
  logic window_open;
  logic in_pause;
  logic pick_any;
  logic [IW-1:0] pick_idx;
  logic pick_hs;
  logic [IW-1:0] cur_idx;
  dca_req_s cur_cmd;
  logic [3:0] slot_cnt;
  logic [DCA_WORD_W:0] sum;
  logic [NDEV-1:0] tier_req;
  logic rsp_ready;
  logic rsp_push;
  dca_rsp_s rsp_word;
  dca_rsp_s rsp_head;
  logic rsp_head_valid;

  // RQ4 high speed first
  assign tier_req = (in_pause && |(sync_req & hs_clean))
                    ? (sync_req & hs_clean) : sync_req;

  // RQ3 nearest first
  dca_prio #(.N(NDEV)) u_prio
  (
    .req_in(tier_req),
    .hs_in(hs_clean),
    .any_out(pick_any),
    .idx_out(pick_idx),
    .hs_out(pick_hs)
  );

  // RQ1 sample at memory cycle
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      sync_req <= '0;
    end
    else
    begin
      // A grant clears its bit; the served mask keeps a device that was
      // just answered, still high through the synchroniser, from a rerun
      if (mem_cycle_start_in)
      begin
        sync_req <= sync_req | (req_clean & ~served);
      end
      if (state == ST_IDLE && window_open && pick_any && rsp_ready)
      begin
        sync_req[pick_idx] <= 1'b0;
      end
    end
  end

  // Served until the device is seen to drop its request
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      served <= '0;
    end
    else
    begin
      served <= served & req_clean;
      if (state == ST_IDLE && window_open && pick_any && rsp_ready)
      begin
        served[pick_idx] <= 1'b1;
      end
    end
  end

  // RQ2 wait for instruction end
  // RQ4 or a pause point
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      window_open <= 1'b0;
      in_pause <= 1'b0;
    end
    else if (!window_open && (instr_end_in || (PAUSING && pause_point_in)))
    begin
      window_open <= 1'b1;
      in_pause <= !instr_end_in;
    end
    else if (state == ST_EXIT)
    begin
      window_open <= 1'b0;
      in_pause <= 1'b0;
    end
  end

  assign sum = {1'b0, mem_rdata_in} + ((cur_cmd.op == DCA_OP_INC)
               ? {1'b0, DCA_WORD_ONE} : {1'b0, cur_cmd.data});

  // RQ10 interleave one word each
  // RQ12 speed from chain
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      state <= ST_IDLE;
      cur_idx <= '0;
      cur_cmd <= '0;
      slot_cnt <= '0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (window_open && pick_any && rsp_ready)
          begin
            cur_idx <= pick_idx;
            // RQ16 device holds command
            cur_cmd <= dev_cmd_in[pick_idx];
            slot_cnt <= pick_hs ? DCA_HS_CNT : DCA_STD_CNT;
            state <= (dev_cmd_in[pick_idx].op == DCA_OP_IN)
                     ? ST_WRITE : ST_READ;
          end
          else if (window_open && !pick_any)
          begin
            state <= ST_EXIT;
          end
        end
        ST_READ:
        begin
          state <= (cur_cmd.op == DCA_OP_OUT) ? ST_HOLD : ST_WRITE;
        end
        ST_WRITE:
        begin
          state <= ST_HOLD;
        end
        ST_HOLD:
        begin
          if (slot_cnt <= 4'h1)
          begin
            state <= ST_IDLE;
          end
          slot_cnt <= slot_cnt - 4'h1;
        end
        ST_EXIT:
        begin
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------
  // RQ6 in, out, increment, add
  // RQ7 sum written back
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      mem_en_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_addr_out <= '0;
      mem_wdata_out <= '0;
    end
    else
    begin
      mem_en_out <= 1'b0;
      mem_we_out <= 1'b0;
      if (state == ST_IDLE && window_open && pick_any && rsp_ready)
      begin
        mem_en_out <= 1'b1;
        mem_addr_out <= dev_cmd_in[pick_idx].addr;
        if (dev_cmd_in[pick_idx].op == DCA_OP_IN)
        begin
          mem_we_out <= 1'b1;
          mem_wdata_out <= dev_cmd_in[pick_idx].data;
        end
      end
      else if (state == ST_READ && cur_cmd.op != DCA_OP_OUT)
      begin
        mem_en_out <= 1'b1;
        mem_we_out <= 1'b1;
        mem_wdata_out <= sum[DCA_WORD_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Answer path through the FIFO
  // ----------------------------------------------------------------
  // RQ8 carry out is overflow
  always_comb
  begin
    rsp_push = 1'b0;
    rsp_word = '0;
    rsp_word.dev = 3'(cur_idx);
    if (state == ST_READ)
    begin
      rsp_push = 1'b1;
      if (cur_cmd.op == DCA_OP_OUT)
      begin
        rsp_word.data = mem_rdata_in;
      end
      else if (cur_cmd.op == DCA_OP_ADD && !HAS_ADD)
      begin
        rsp_word.data = DCA_WORD_ZERO;
      end
      else
      begin
        rsp_word.data = sum[DCA_WORD_W-1:0];
        rsp_word.ovf = sum[DCA_WORD_W];
      end
    end
    else if (state == ST_WRITE && cur_cmd.op == DCA_OP_IN)
    begin
      rsp_push = 1'b1;
    end
  end

  // Grants stall when the answer queue is full
  dca_fifo #(.WIDTH(DCA_RSP_W), .DEPTH(DEPTH)) u_fifo
  (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .wr_data_in(rsp_word),
    .wr_valid_in(rsp_push),
    .wr_ready_out(rsp_ready),
    .rd_data_out(rsp_head),
    .rd_valid_out(rsp_head_valid),
    .rd_ready_in(dev_rsp_ready_in && !dev_rsp_valid_out)
  );

  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      dev_done_out <= '0;
      dev_ovf_out <= '0;
      dev_data_out <= '0;
      dev_rsp_valid_out <= 1'b0;
    end
    else
    begin
      dev_done_out <= '0;
      dev_ovf_out <= '0;
      dev_rsp_valid_out <= 1'b0;
      if (rsp_head_valid && dev_rsp_ready_in && !dev_rsp_valid_out)
      begin
        dev_rsp_valid_out <= 1'b1;
        dev_done_out[rsp_head.dev] <= 1'b1;
        dev_ovf_out[rsp_head.dev] <= rsp_head.ovf;
        dev_data_out <= rsp_head.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer handshake
  // ----------------------------------------------------------------
  // RQ5 channel before interrupt
  // RQ14 interrupt only at end
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      chan_busy_out <= 1'b0;
      start_irq_out <= 1'b0;
      fetch_next_out <= 1'b0;
      resume_out <= 1'b0;
    end
    else
    begin
      chan_busy_out <= window_open && state != ST_EXIT;
      start_irq_out <= state == ST_EXIT && !in_pause && irq_pending_in;
      fetch_next_out <= state == ST_EXIT && !in_pause && !irq_pending_in;
      resume_out <= state == ST_EXIT && in_pause;
    end
  end

  // RQ15 highest unmasked source
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      pending_source_out <= DCA_CODE_NONE;
    end
    else if (pending_source_query_in)
    begin
      pending_source_out <= DCA_CODE_NONE;
      for (int i = NDEV-1; i >= 0; i--)
      begin
        if (dev_irq_in[i] && !irq_mask_in[i])
        begin
          pending_source_out <= dev_code_in[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_no_irq_in_pause;
    @(posedge core_clk_in) disable iff (!resetn_in)
    in_pause |=> !start_irq_out;
  endproperty
  a_no_irq_in_pause: assert property (p_no_irq_in_pause) // RQ14
    else $error("interrupt entered at a pause point");

  property p_irq_after_channel;
    @(posedge core_clk_in) disable iff (!resetn_in)
    start_irq_out |-> $past(state) == ST_EXIT && !$past(pick_any);
  endproperty
  a_irq_after_channel: assert property (p_irq_after_channel) // RQ5
    else $error("interrupt before channel drained");

  property p_grant_waits;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (state == ST_IDLE && !window_open) |=> state != ST_READ && state != ST_WRITE;
  endproperty
  a_grant_waits: assert property (p_grant_waits) // RQ2
    else $error("grant outside a service window");

  property p_ovf_carry;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (rsp_push && state == ST_READ && cur_cmd.op == DCA_OP_INC)
      |-> rsp_word.ovf == (mem_rdata_in == 16'hFFFF);
  endproperty
  a_ovf_carry: assert property (p_ovf_carry) // RQ8
    else $error("overflow does not match increment carry");

  sequence s_rmw_start;
    state == ST_READ && cur_cmd.op != DCA_OP_OUT;
  endsequence
  property p_rmw_write;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_rmw_start |=> mem_en_out && mem_we_out;
  endproperty
  a_rmw_write: assert property (p_rmw_write) // RQ7
    else $error("sum not written back");

  property p_exit_fetch;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (state == ST_EXIT && !in_pause)
      |=> (start_irq_out || fetch_next_out) && !resume_out;
  endproperty
  a_exit_fetch: assert property (p_exit_fetch) // RQ5
    else $error("no interrupt or fetch after channel service");

  property p_nearest;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (state == ST_IDLE && window_open && pick_any && rsp_ready && !in_pause)
      |=> (state != ST_IDLE)
        && (($past(sync_req) & ((NDEV)'(1) << cur_idx) - 1'b1) == '0);
  endproperty
  a_nearest: assert property (p_nearest) // RQ3
    else $error("a nearer request was passed over");

  property p_sample;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (mem_cycle_start_in && |(req_clean & ~served) && !window_open)
      |=> |sync_req;
  endproperty
  a_sample: assert property (p_sample) // RQ1
    else $error("request not synchronised at memory cycle");

endmodule // dca_arbiter

`default_nettype wire

// ===== dca_pkg.sv
/*
  Shared constants, operation codes and carrier structs for the data
  channel arbiter. Assumes a 16-bit memory word and 15-bit word address.
*/
`default_nettype none

package dca_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DCA_WORD_W = 16;
  localparam int DCA_ADDR_W = 15;
  localparam int DCA_CODE_W = 6;
  localparam int DCA_NDEV = 8;
  localparam int DCA_FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DCA_CLK_NS = 50;
  localparam int DCA_STD_SLOT_NS = 200;
  localparam int DCA_HS_SLOT_NS = 100;
  // Least times: round up to whole cycles
  localparam int DCA_STD_CYC = (DCA_STD_SLOT_NS + DCA_CLK_NS - 1) / DCA_CLK_NS;
  localparam int DCA_HS_CYC = (DCA_HS_SLOT_NS + DCA_CLK_NS - 1) / DCA_CLK_NS;
  localparam logic [3:0] DCA_STD_CNT = 4'(DCA_STD_CYC);
  localparam logic [3:0] DCA_HS_CNT = 4'(DCA_HS_CYC);

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    DCA_OP_IN = 2'h0,
    DCA_OP_OUT = 2'h1,
    DCA_OP_INC = 2'h2,
    DCA_OP_ADD = 2'h3
  } dca_op_e;

  localparam logic [DCA_WORD_W-1:0] DCA_WORD_ONE = 16'h0001;
  localparam logic [DCA_WORD_W-1:0] DCA_WORD_ZERO = 16'h0000;
  localparam logic [DCA_CODE_W-1:0] DCA_CODE_NONE = 6'h00;

  // Request that a device holds while waiting
  typedef struct packed
  {
    dca_op_e op;
    logic [DCA_ADDR_W-1:0] addr;
    logic [DCA_WORD_W-1:0] data;
  } dca_req_s;

  // Answer returned to a device
  typedef struct packed
  {
    logic [2:0] dev;
    logic [DCA_WORD_W-1:0] data;
    logic ovf;
  } dca_rsp_s;

  localparam int DCA_RSP_W = $bits(dca_rsp_s);

endpackage

`default_nettype wire

// ===== dca_fifo.sv
/*
  Parameterised flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module dca_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  assign wr_ready_out = (count != (AW+1)'(DEPTH));
  assign rd_valid_out = (count != '0);
  assign rd_data_out = mem[rd_ptr];
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;

  always_ff @(posedge core_clk_in)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        count <= count + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count <= count - 1'b1;
      end
    end
  end

  property p_no_overflow;
    @(posedge core_clk_in) disable iff (!resetn_in)
    count <= (AW+1)'(DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("fifo count above depth");

endmodule // dca_fifo

`default_nettype wire

// ===== dca_prio.sv
/*
  Fixed-priority picker: lowest index (nearest position) wins, and
  a chain signal marks whether the winner is in the high-speed tier.
  Assumes combinational use inside the arbiter's clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module dca_prio
#(
  parameter int N = 8
)
(
  input wire logic [N-1:0] req_in,
  input wire logic [N-1:0] hs_in,
  output logic any_out,
  output logic [$clog2(N)-1:0] idx_out,
  output logic hs_out
);
  always_comb
  begin
    any_out = 1'b0;
    idx_out = '0;
    hs_out = 1'b0;
    for (int i = N-1; i >= 0; i--)
    begin
      if (req_in[i])
      begin
        any_out = 1'b1;
        idx_out = ($clog2(N))'(i);
        hs_out = hs_in[i];
      end
    end
  end
endmodule // dca_prio

`default_nettype wire

// ===== dca_dev_model.sv
/*
  Peripheral interface model that stands on the device side of the
  data channel arbiter. It assumes the bench pulses go_in for one
  cycle, with the command already set up on cmd_in.
*/
`timescale 1ns/1ps
`default_nettype none

module dca_dev_model
import dca_pkg::*;
#(
  parameter int N = 8,
  parameter int HS_N = 2
)
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [N-1:0] go_in,
  input wire dca_req_s [N-1:0] cmd_in,
  input wire logic [N-1:0] done_in,
  output logic [N-1:0] req_out,
  output logic [N-1:0] hs_out,
  output var dca_req_s [N-1:0] cmd_out
);
  // --------------------------------------------------------------
  // Request holding
  // --------------------------------------------------------------
  // fast tier nearest
  assign hs_out = N'((1 << HS_N) - 1);

  always_ff @(posedge core_clk_in)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (!resetn_in)
        req_out[i] <= 1'b0;
      else if (go_in[i])
        req_out[i] <= 1'b1;
      else if (done_in[i])
        req_out[i] <= 1'b0;
      // An idle interface inverts its lines every cycle, so the stale command returns every other cycle
      if (go_in[i])
        cmd_out[i] <= cmd_in[i];
      else if (!req_out[i] || done_in[i])
        cmd_out[i] <= ~cmd_out[i];
    end
  end
endmodule // dca_dev_model

`default_nettype wire

// ===== data_channel_arbiter_test.sv
/*
  Self-checking bench for the data channel arbiter, with a small
  memory and a free-running sequencer. It assumes the standard
  variant with the add option present.
*/
`timescale 1ns/1ps
`default_nettype none

module data_channel_arbiter_test;
  import dca_pkg::*;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] go = '0;
  dca_req_s [7:0] cmd = '0;
  dca_req_s [7:0] dcmd;
  logic [7:0] req, hs, done, ovf, irq = '0, mask = '0;
  logic [15:0] dout, mwd, rdata;
  logic [15:0] mem [16] = '{default: '0};
  logic [14:0] maddr;
  logic [5:0] code [8];
  logic [5:0] src;
  logic rvalid, busy, sirq, fetch, resume, men, mwe;
  logic ready = 1'b1, query = 1'b0, mcs = 1'b0, iend = 1'b0;
  logic kick = 1'b0, ipend = 1'b0, auto_end = 1'b1;
  int err_total = 0, check_count = 0, cyc = 0, t_done = 0, irq_cyc = 0;
  int n_irq = 0, n_fetch = 0, n_res = 0;
  logic [19:0] rsp_q [$];

  dca_arbiter #(.NDEV(8)) dut (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .dev_req_in(req), .dev_hs_chain_in(hs),
    .dev_cmd_in(dcmd), .dev_done_out(done), .dev_ovf_out(ovf),
    .dev_data_out(dout), .dev_rsp_valid_out(rvalid),
    .dev_rsp_ready_in(ready), .dev_irq_in(irq), .irq_mask_in(mask),
    .dev_code_in(code), .pending_source_query_in(query),
    .pending_source_out(src), .mem_cycle_start_in(mcs),
    .instr_end_in(iend | kick), .pause_point_in(1'b0),
    .irq_pending_in(ipend), .chan_busy_out(busy), .start_irq_out(sirq),
    .fetch_next_out(fetch), .resume_out(resume), .mem_en_out(men),
    .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwd),
    .mem_rdata_in(rdata));

  dca_dev_model #(.N(8), .HS_N(2)) u_dev (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .go_in(go), .cmd_in(cmd), .done_in(done),
    .req_out(req), .hs_out(hs), .cmd_out(dcmd));

  // --------------------------------------------------------------
  // Clock, sequencer, memory and answer monitor
  // --------------------------------------------------------------
  always #25 core_clk_in = ~core_clk_in;

  // Read data follows the address at once: the arbiter takes it in the
  // cycle of its read state
  assign rdata = mem[maddr[3:0]];

  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    mcs <= (cyc % 4 == 0);
    iend <= auto_end && (cyc % 8 == 5);
    if (men && mwe)
      mem[maddr[3:0]] <= mwd;
    for (int i = 0; i < 8; i++)
      if (rvalid && done[i])
      begin
        rsp_q.push_back({3'(i), ovf[i], dout});
        t_done <= cyc;
      end
    if (sirq)
    begin
      n_irq <= n_irq + 1;
      irq_cyc <= cyc;
    end
    if (fetch)
      n_fetch <= n_fetch + 1;
    if (resume)
      n_res <= n_res + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic issue(input int d, input dca_op_e op,
    input logic [14:0] a, input logic [15:0] w);
    cmd[d] <= '{op, a, w};
    go[d] <= 1'b1;
  endtask

  task automatic wait_rsp(input int n);
    for (int k = 0; k < 300 && rsp_q.size() < n; k++)
      @(posedge core_clk_in);
    check("answer count", rsp_q.size(), n);
  endtask

  task automatic pop_check(input string what, input logic [19:0] exp);
    logic [19:0] r;
    r = rsp_q.size() ? rsp_q.pop_front() : 20'hFFFFF;
    check(what, r, exp);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_ops;
    dca_op_e ops [5] = '{DCA_OP_IN, DCA_OP_OUT, DCA_OP_INC, DCA_OP_ADD,
      DCA_OP_INC};
    logic [15:0] wv [5] = '{16'hABCD, 16'h0, 16'h0, 16'h0002, 16'h0};
    logic [15:0] ev [5] = '{16'h0, 16'h1234, 16'h0, 16'h0001, 16'h0008};
    for (int i = 0; i < 5; i++)
    begin
      @(posedge core_clk_in);
      issue(1, ops[i], 15'(i), wv[i]);
      @(posedge core_clk_in);
      go <= '0;
      wait_rsp(1);
      pop_check("op answer", {3'd1, i inside {2, 3}, ev[i]});
    end
    check("in stored", mem[0], 16'hABCD);
    check("sum stored", mem[3], 16'h0001);
    $display("test ops done");
  endtask

  task automatic t_prio;
    int ord [3] = '{0, 3, 6};
    @(posedge core_clk_in);
    for (int k = 2; k >= 0; k--)
      issue(ord[k], DCA_OP_INC, 15'h8, 16'h0);
    @(posedge core_clk_in);
    go <= '0;
    wait_rsp(3);
    for (int k = 0; k < 3; k++)
      pop_check("grant order", {3'(ord[k]), 1'b0, 16'(k + 1)});
    $display("test priority done");
  endtask

  task automatic t_irq;
    int n0, f0;
    @(posedge core_clk_in);
    auto_end <= 1'b0;
    repeat (10) @(posedge core_clk_in);
    ipend <= 1'b1;
    issue(2, DCA_OP_OUT, 15'h1, 16'h0);
    n0 = n_irq;
    f0 = n_fetch;
    @(posedge core_clk_in);
    go <= '0;
    repeat (30) @(posedge core_clk_in);
    check("no service mid instr", rsp_q.size(), 0);
    check("no irq mid instr", n_irq, n0);
    kick <= 1'b1;
    @(posedge core_clk_in);
    kick <= 1'b0;
    @(posedge core_clk_in);
    #1;
    check("busy in window", busy, 1'b1);
    wait_rsp(1);
    repeat (20) @(posedge core_clk_in);
    pop_check("out answer", {3'd2, 1'b0, 16'h1234});
    check("irq entered", n_irq, n0 + 1);
    check("channel first", irq_cyc > t_done, 1);
    check("no fetch before irq", n_fetch, f0);
    check("no resume", n_res, 0);
    ipend <= 1'b0;
    auto_end <= 1'b1;
    $display("test ordering done");
  endtask

  task automatic t_query(input logic [7:0] m, input logic [5:0] exp);
    @(posedge core_clk_in);
    irq <= 8'h64;
    mask <= m;
    query <= 1'b1;
    @(posedge core_clk_in);
    query <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1;
    check("pending source", src, exp);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    for (int i = 0; i < 8; i++)
      code[i] = 6'(16 + i);
    mem[1] = 16'h1234;
    mem[2] = 16'hFFFF;
    mem[3] = 16'hFFFF;
    mem[4] = 16'h0007;
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    t_ops();
    t_prio();
    t_irq();
    t_query(8'h04, 6'h15);
    t_query(8'hFF, 6'h00);
    $display("test query done");
    end_of_test();
  end

  // Budget is several times the expected run length
  initial
  begin
    repeat (4000) @(posedge core_clk_in);
    err_total++;
    end_of_test();
  end
endmodule // data_channel_arbiter_test

`default_nettype wire
